// >>> verilog/pcsc_defs.svh
// Offsets, field positions, reset values and timing counts
// Assumes inclusion by the single design module pcsc_serial_config; the package does not include it
`ifndef PCSC_DEFS_SVH
`define PCSC_DEFS_SVH

// ==========================================================
// Instruction word fields
`define PCSC_WORD_W       24
`define PCSC_DATA_HI      23
`define PCSC_DATA_LO      11
`define PCSC_GSEL_BIT     10
`define PCSC_ADDR_HI      9
`define PCSC_ADDR_LO      6
`define PCSC_CHAN_BIT     5
`define PCSC_READ_BIT     4
`define PCSC_FUNC_HI      3
`define PCSC_FUNC_LO      0

// ==========================================================
// Chip function codes
`define PCSC_F_IDLE       4'h0
`define PCSC_F_PART_ID    4'h1
`define PCSC_F_REVISION   4'h2
`define PCSC_F_AUTOCAL    4'h3
`define PCSC_F_GSWITCH    4'h4
`define PCSC_F_CALSCALE   4'h5
`define PCSC_F_DIAG       4'h6
`define PCSC_F_RESET      4'hF

// ==========================================================
// Channel function codes
`define PCSC_C_STATE      4'h0
`define PCSC_C_HIZ        4'h1
`define PCSC_C_LOZ        4'h2
`define PCSC_C_GROUP      4'hF

// ==========================================================
// State field layout and reset values
`define PCSC_OVR_LEVEL    6
`define PCSC_OVR_DRIVE    7
`define PCSC_OVR_EN       8
`define PCSC_CALSCALE_RST 8'hFF

// ==========================================================
// Timing counts in serial-clock edges
`define PCSC_EXEC_EDGES   7
`define PCSC_CAL_EDGES    576
`define PCSC_READ_BITS    24
`define PCSC_READ_LEAD    5

`endif

// >>> verilog/pcsc_pkg.sv
// Types shared by the serial configuration block
// Assumes pcsc_defs.svh sits on the include path
package pcsc_pkg;

    // ======================================================
    // Decoded instruction word
    typedef struct packed {
        logic [12:0] data;
        logic        group_sel;
        logic [3:0]  addr;
        logic        chan;
        logic        read;
        logic [3:0]  func;
    } pcsc_instr_t;

    // ======================================================
    // Per-lane driver controls
    typedef struct packed {
        logic [5:0] switches;
        logic       drive_level;
        logic       drive_enable;
    } pcsc_lane_out_t;

    typedef enum logic [1:0] {
        CAL_IDLE,
        CAL_RUN,
        CAL_APPLY
    } pcsc_cal_state_t;

endpackage : pcsc_pkg

// >>> verilog/pcsc_serial_config.sv
// Instruction decoder and register map of the serial config port
// Assumes serial_data_in, load_strobe and comparator inputs are
// synchronous to serial_clock; the analog side acts on outputs.
`include "pcsc_defs.svh"

// Operation
// (R01) Eight group writes, one per group
// (R02) Group writes write-only, effects readable per lane
// (R03) Group write overrides member lane states
// (R04) Controller encodes group write bits properly
// (R05) Each lane holds 8-bit group membership
// (R06) Calibration trigger write starts autocal
// (R07) All four lanes calibrate in parallel
// (R08) Calibration takes 576 clock edges
// (R09) No continuity switch closing during calibration; not enforced, continuity_test_circuit follows state bit 4 while cal_busy
// (R10) New codes applied to every driver
// (R11) Controller recalibrates after level changes
// (R12) Group and lane state share layout
// (R13) Latch at strobe, execute within seven edges
// (R14) Readback: five ignored, thirteen data, six zeros
// (R15) Lane addresses 0 to 3 accepted
// (R16) Overrides act only when override enabled
// (R17) Fixed instruction word field layout
// (R18) Function codes per lane and chip
// (R19) Comparator states read back, not writable
module pcsc_serial_config
    import pcsc_pkg::*;
#(
    parameter int          LANES    = 4,
    parameter int          GROUPS   = 8,
    parameter logic [12:0] PART_ID  = 13'h0A5A, // Arbitrary value
    parameter logic [12:0] REVISION = 13'h0003, // Arbitrary value
    parameter logic [7:0]  CAL_CODE = 8'h80     // Stand-in result
) (
    input  logic                 serial_clock,
    input  logic                 reset,
    input  logic                 serial_data_in,
    input  logic                 load_strobe,
    output logic                 serial_data_out,
    input  logic [LANES-1:0]     comparator_a_state,
    input  logic [LANES-1:0]     comparator_b_state,
    input  logic [LANES-1:0]     external_level_select,
    input  logic [LANES-1:0]     external_drive_enable,
    output pcsc_lane_out_t [LANES-1:0] lane_out,
    output logic [LANES-1:0]     continuity_test_circuit,
    output logic                 global_switch_control,
    output logic [7:0]           chipwide_cal_scale,
    output logic                 cal_busy,
    output logic                 cal_apply,
    output logic [LANES-1:0][7:0] high_level_z_code,
    output logic [LANES-1:0][7:0] low_level_z_code
);

    // ======================================================
    // Shift and latch
    logic [23:0]       shift_reg;
    pcsc_instr_t       instr_reg;
    logic              exec_reg;
    logic [2:0]        exec_cnt_reg;
    logic              soft_reset;

    always_ff @(posedge serial_clock or posedge reset) begin
        if (reset) begin
            shift_reg <= 24'h000000;
        end else begin
            shift_reg <= {shift_reg[22:0], serial_data_in};
        end
    end

    // Word latched on the strobe edge, decoded next edge      (R13)
    always_ff @(posedge serial_clock or posedge reset) begin
        if (reset) begin
            instr_reg <= '0;
            exec_reg  <= 1'b0;
        end else begin
            exec_reg <= load_strobe;
            if (load_strobe) begin
                instr_reg <= {shift_reg[22:0], serial_data_in}; // (R17)
            end
        end
    end

    // Execution window count, not read or output anywhere
    always_ff @(posedge serial_clock or posedge reset) begin
        if (reset) begin
            exec_cnt_reg <= 3'h0;
        end else if (load_strobe) begin
            exec_cnt_reg <= 3'(`PCSC_EXEC_EDGES);               // (R13)
        end else if (exec_cnt_reg != 3'h0) begin
            exec_cnt_reg <= exec_cnt_reg - 3'h1;
        end
    end

    // ======================================================
    // Decode
    logic is_chip;
    logic is_lane;
    logic is_group;
    logic wr_en;

    function automatic logic lane_hit(input pcsc_instr_t i,
                                      input int         n);
        return i.chan && !i.group_sel && i.addr == 4'(n);   // (R15)
    endfunction : lane_hit

    assign is_chip  = !instr_reg.chan;                       // (R18)
    assign is_lane  = instr_reg.chan && !instr_reg.group_sel
                      && instr_reg.addr < 4'(LANES);         // (R15)
    assign is_group = instr_reg.chan && instr_reg.group_sel
                      && instr_reg.func == 4'h0
                      && !instr_reg.read
                      && instr_reg.addr < 4'(GROUPS);        // (R01)
    assign wr_en    = exec_reg && !instr_reg.read;

    assign soft_reset = wr_en && is_chip
                        && instr_reg.func == `PCSC_F_RESET
                        && instr_reg.data[0];

    // ======================================================
    // Lane registers
    logic [LANES-1:0][8:0]  state_reg;
    logic [LANES-1:0][7:0]  group_reg;
    logic [LANES-1:0][7:0]  hiz_reg;
    logic [LANES-1:0][7:0]  loz_reg;
    logic                   group_clear;

    assign group_clear = wr_en && is_chip
                         && instr_reg.func == `PCSC_F_RESET
                         && instr_reg.data[1];

    // Group write has priority only by being a distinct opcode
    always_ff @(posedge serial_clock or posedge reset) begin
        if (reset) begin
            state_reg <= '0;
        end else if (soft_reset) begin
            state_reg <= '0;
        end else if (wr_en) begin
            for (int n = 0; n < LANES; n++) begin
                if (lane_hit(instr_reg, n)
                    && instr_reg.func == `PCSC_C_STATE) begin
                    // Comparator bits D10..D9 not stored          (R19)
                    state_reg[n] <= instr_reg.data[8:0];      // (R12)
                end else if (is_group
                    && group_reg[n][instr_reg.addr[2:0]]) begin
                    state_reg[n] <= instr_reg.data[8:0]; // (R03) (R12)
                end
            end
        end
    end

    always_ff @(posedge serial_clock or posedge reset) begin
        if (reset) begin
            group_reg <= '0;
        end else if (soft_reset || group_clear) begin
            group_reg <= '0;
        end else if (wr_en) begin
            for (int n = 0; n < LANES; n++) begin
                if (lane_hit(instr_reg, n)
                    && instr_reg.func == `PCSC_C_GROUP) begin
                    group_reg[n] <= instr_reg.data[7:0];      // (R05)
                end
            end
        end
    end

    // ======================================================
    // Chip registers
    logic       cal_req_reg;
    logic       gswitch_reg;
    logic [7:0] calscale_reg;

    always_ff @(posedge serial_clock or posedge reset) begin
        if (reset) begin
            gswitch_reg  <= 1'b0;
            calscale_reg <= `PCSC_CALSCALE_RST;
        end else if (soft_reset) begin
            gswitch_reg  <= 1'b0;
            calscale_reg <= `PCSC_CALSCALE_RST;
        end else if (wr_en && is_chip) begin
            if (instr_reg.func == `PCSC_F_GSWITCH) begin
                gswitch_reg <= instr_reg.data[0];
            end
            if (instr_reg.func == `PCSC_F_CALSCALE) begin
                calscale_reg <= instr_reg.data[7:0];
            end
        end
    end

    assign cal_req_reg = wr_en && is_chip
                         && instr_reg.func == `PCSC_F_AUTOCAL
                         && instr_reg.data[0];               // (R06)

    // ======================================================
    // Calibration sequencer
    pcsc_cal_state_t cal_state_reg;
    logic [9:0]      cal_cnt_reg;

    always_ff @(posedge serial_clock or posedge reset) begin
        if (reset) begin
            cal_state_reg <= CAL_IDLE;
            cal_cnt_reg   <= 10'h000;
        end else if (soft_reset) begin
            cal_state_reg <= CAL_IDLE;
            cal_cnt_reg   <= 10'h000;
        end else begin
            case (cal_state_reg)
                CAL_IDLE: begin
                    if (cal_req_reg) begin
                        cal_state_reg <= CAL_RUN;             // (R06)
                        cal_cnt_reg   <= 10'(`PCSC_CAL_EDGES - 1);
                    end
                end
                CAL_RUN: begin
                    if (cal_cnt_reg == 10'h000) begin
                        cal_state_reg <= CAL_APPLY;           // (R08)
                    end else begin
                        cal_cnt_reg <= cal_cnt_reg - 10'h001;
                    end
                end
                default: begin
                    cal_state_reg <= CAL_IDLE;
                end
            endcase
        end
    end

    // Codes loaded for every lane at once, drivers on or off
    always_ff @(posedge serial_clock or posedge reset) begin
        if (reset) begin
            hiz_reg <= '0;
            loz_reg <= '0;
        end else if (soft_reset) begin
            hiz_reg <= '0;
            loz_reg <= '0;
        end else if (cal_state_reg == CAL_APPLY) begin
            for (int n = 0; n < LANES; n++) begin
                hiz_reg[n] <= CAL_CODE;                 // (R07) (R10)
                loz_reg[n] <= CAL_CODE;                 // (R07) (R10)
            end
        end else if (wr_en) begin
            for (int n = 0; n < LANES; n++) begin
                if (lane_hit(instr_reg, n)) begin
                    if (instr_reg.func == `PCSC_C_HIZ) begin
                        hiz_reg[n] <= instr_reg.data[7:0];
                    end
                    if (instr_reg.func == `PCSC_C_LOZ) begin
                        loz_reg[n] <= instr_reg.data[7:0];
                    end
                end
            end
        end
    end

    // ======================================================
    // Readback
    logic [12:0] rd_data;
    logic [23:0] rd_shift_reg;
    logic [4:0]  rd_cnt_reg;
    logic [3:0]  rd_lane;

    always_comb begin
        rd_data = 13'h0000;
        rd_lane = instr_reg.addr;
        if (is_chip) begin
            if (instr_reg.func == `PCSC_F_PART_ID) begin
                rd_data = PART_ID;
            end else if (instr_reg.func == `PCSC_F_REVISION) begin
                rd_data = REVISION;
            end else if (instr_reg.func == `PCSC_F_AUTOCAL) begin
                rd_data = {12'h000, cal_busy};
            end else if (instr_reg.func == `PCSC_F_GSWITCH) begin
                rd_data = {12'h000, gswitch_reg};
            end else if (instr_reg.func == `PCSC_F_CALSCALE) begin
                rd_data = {5'h00, calscale_reg};
            end
        end else if (is_lane) begin
            if (instr_reg.func == `PCSC_C_STATE) begin
                rd_data = {2'h0, comparator_a_state[rd_lane[1:0]],
                           comparator_b_state[rd_lane[1:0]],
                           state_reg[rd_lane[1:0]]};    // (R02) (R19)
            end else if (instr_reg.func == `PCSC_C_HIZ) begin
                rd_data = {5'h00, hiz_reg[rd_lane[1:0]]};
            end else if (instr_reg.func == `PCSC_C_LOZ) begin
                rd_data = {5'h00, loz_reg[rd_lane[1:0]]};
            end else if (instr_reg.func == `PCSC_C_GROUP) begin
                rd_data = {5'h00, group_reg[rd_lane[1:0]]};
            end
        end
    end

    // Group writes are never read: the read bit blocks them   (R02)
    always_ff @(posedge serial_clock or posedge reset) begin
        if (reset) begin
            rd_shift_reg <= 24'h000000;
            rd_cnt_reg   <= 5'h00;
        end else if (exec_reg && instr_reg.read && !is_group) begin
            rd_shift_reg <= {6'h00, rd_data, 5'h00};          // (R14)
            rd_cnt_reg   <= 5'(`PCSC_READ_BITS);
        end else if (rd_cnt_reg != 5'h00) begin
            rd_shift_reg <= {1'b0, rd_shift_reg[23:1]};
            rd_cnt_reg   <= rd_cnt_reg - 5'h01;
        end
    end

    // Echo path simplified to the oldest shifted bit
    always_ff @(negedge serial_clock or posedge reset) begin
        if (reset) begin
            serial_data_out <= 1'b0;
        end else if (rd_cnt_reg != 5'h00) begin
            serial_data_out <= rd_shift_reg[0];               // (R14)
        end else begin
            serial_data_out <= shift_reg[23];
        end
    end

    // ======================================================
    // Driver controls
    always_comb begin
        for (int n = 0; n < LANES; n++) begin
            lane_out[n].switches = state_reg[n][5:0];
            if (state_reg[n][`PCSC_OVR_EN]) begin
                lane_out[n].drive_level =
                    state_reg[n][`PCSC_OVR_LEVEL];            // (R16)
                lane_out[n].drive_enable =
                    state_reg[n][`PCSC_OVR_DRIVE];            // (R16)
            end else begin
                lane_out[n].drive_level  = external_level_select[n];
                lane_out[n].drive_enable = external_drive_enable[n];
            end
            continuity_test_circuit[n] = state_reg[n][4];
        end
    end

    assign global_switch_control = gswitch_reg;
    assign chipwide_cal_scale    = calscale_reg;
    assign cal_busy              = cal_state_reg != CAL_IDLE;
    assign cal_apply             = cal_state_reg == CAL_APPLY;
    assign high_level_z_code     = hiz_reg;
    assign low_level_z_code      = loz_reg;

endmodule : pcsc_serial_config

// >>> tb/pcsc_serial_config_checker.sv
// Port-level assertions for the serial configuration block
// Assumes binding into pcsc_serial_config; one clock domain
module pcsc_serial_config_checker
    import pcsc_pkg::*;
#(
    parameter int          LANES    = 4,
    parameter logic [12:0] PART_ID  = 13'h0000,
    parameter logic [7:0]  CAL_CODE = 8'h00
) (
    input logic                       serial_clock,
    input logic                       reset,
    input logic                       serial_data_in,
    input logic                       load_strobe,
    input logic                       serial_data_out,
    input pcsc_lane_out_t [LANES-1:0] lane_out,
    input logic [LANES-1:0]           continuity_test_circuit,
    input logic                       cal_busy,
    input logic                       cal_apply,
    input logic [LANES-1:0][7:0]      high_level_z_code,
    input logic [LANES-1:0][7:0]      low_level_z_code
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int CAL_EDGES = 576;
    default clocking @(posedge serial_clock); endclocking
    default disable iff (reset);

    // ========
    // Helper logic: own copy of the shifted word
    logic [23:0]        sh_reg;
    logic [23:0]        word;
    logic [12:0]        cap_reg;
    logic [9:0]         cnt_reg;
    logic [LANES*6-1:0] sw;
    logic [LANES-1:0]   s5;
    assign word = {sh_reg[22:0], serial_data_in};
    always_comb begin
        for (int l = 0; l < LANES; l++) begin
            sw[l*6 +: 6] = lane_out[l].switches;
            s5[l]        = lane_out[l].switches[4];
        end
    end
    always_ff @(posedge serial_clock or posedge reset) begin
        if (reset)
            sh_reg <= '0;
        else
            sh_reg <= word;
    end
    // Readback lands LSB first
    always_ff @(posedge serial_clock or posedge reset) begin
        if (reset)
            cap_reg <= '0;
        else
            cap_reg <= {serial_data_out, cap_reg[12:1]};
    end
    always_ff @(posedge serial_clock or posedge reset) begin
        if (reset)
            cnt_reg <= '0;
        else
            cnt_reg <= cal_busy ? cnt_reg + 10'h001 : 10'h000;
    end

    // ========
    // Properties
    sequence s_cal_trig;
        load_strobe && word[5:0] == 6'h03 && word[11];
    endsequence
    sequence s_lane0_wr;
        load_strobe && word[10:0] == 11'h020;
    endsequence
    sequence s_tail;
        !serial_data_out [*6];
    endsequence
    property p_cal_start;
        s_cal_trig |-> ##2 cal_busy;
    endproperty
    property p_cal_len;
        cal_apply |-> cnt_reg == CAL_EDGES;
    endproperty
    property p_cal_codes;
        cal_apply |-> ##1 (high_level_z_code == {LANES{CAL_CODE}}
            && low_level_z_code == {LANES{CAL_CODE}});
    endproperty
    property p_cal_end;
        cal_apply |=> !cal_apply && !cal_busy;
    endproperty
    property p_ctc;
        s_lane0_wr |-> ##2 continuity_test_circuit[0] == $past(word[15], 2);
    endproperty
    property p_lane_wr;
        s_lane0_wr |-> ##2 lane_out[0].switches == $past(word[16:11], 2);
    endproperty
    property p_refuse;
        load_strobe && !word[10] && word[9:8] != 2'b00
            && word[5:0] == 6'h20 |-> ##2 sw == $past(sw, 2);
    endproperty
    property p_rd_tail;
        load_strobe && word[4] |-> ##20 s_tail;
    endproperty
    property p_rd_id;
        load_strobe && word[5:0] == 6'h11 |-> ##20 cap_reg == PART_ID;
    endproperty
    a_cal_start: assert property (p_cal_start)
        else $error("calibration did not start");
    a_cal_len: assert property (p_cal_len)
        else $error("calibration length wrong");
    a_cal_codes: assert property (p_cal_codes)
        else $error("calibrated codes not applied");
    a_cal_end: assert property (p_cal_end)
        else $error("calibration did not end");
    a_ctc: assert property (p_ctc)
        else $error("continuity switch mismatch");
    a_lane_wr: assert property (p_lane_wr)
        else $error("lane write not applied");
    a_refuse: assert property (p_refuse)
        else $error("bad lane address changed switches");
    a_rd_tail: assert property (p_rd_tail)
        else $error("readback tail not zero");
    a_rd_id: assert property (p_rd_id)
        else $error("identity readback wrong");
endmodule : pcsc_serial_config_checker

bind pcsc_serial_config pcsc_serial_config_checker #(
    .LANES(LANES), .PART_ID(PART_ID), .CAL_CODE(CAL_CODE)
) u_chk (
    .serial_clock, .reset, .serial_data_in, .load_strobe,
    .serial_data_out, .lane_out, .continuity_test_circuit,
    .cal_busy, .cal_apply, .high_level_z_code, .low_level_z_code
);

// >>> tb/pcsc_host_model.sv
// Tester-side controller model for the serial programming port
// Assumes a free-running serial_clock from the bench
module pcsc_host_model (
    input  logic serial_clock,
    output logic serial_data_in,
    output logic load_strobe,
    input  logic serial_data_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        serial_data_in = 1'b0;
        load_strobe    = 1'b0;
    end
    // MSB first, strobe with the last bit; callers always follow
    // with a word or idle clocks, so decode gets its edges
    task automatic shift_word(input logic [23:0] w,
                              output logic [23:0] rd);
        for (int i = 0; i < 24; i++) begin
            @(posedge serial_clock);
            rd[i] = serial_data_out;
            serial_data_in <= w[23-i];
            load_strobe    <= (i == 23);
        end
    endtask : shift_word
    // Data churns so a stale level never looks valid
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge serial_clock);
            serial_data_in <= ~serial_data_in;
            load_strobe    <= 1'b0;
        end
    endtask : idle
endmodule : pcsc_host_model

// >>> tb/tb_pin_channel_serial_config.sv
// Self-checking bench for the serial configuration block
// Assumes host model and bound checker are compiled first
module tb_pin_channel_serial_config
    import pcsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [12:0] PART_ID  = 13'h1B6E; // Arbitrary value
    localparam logic [7:0]  CAL_CODE = 8'h5C;
    logic serial_clock = 1'b0, reset = 1'b1, serial_data_in, load_strobe;
    logic serial_data_out, global_switch_control, cal_busy, cal_apply;
    logic [3:0] comparator_a_state = '0, comparator_b_state = '0;
    logic [3:0] external_level_select = '0, external_drive_enable = '0;
    logic [3:0] continuity_test_circuit;
    logic [7:0] chipwide_cal_scale;
    pcsc_lane_out_t [3:0] lane_out;
    logic [3:0][7:0] high_level_z_code, low_level_z_code;
    logic [31:0] lfsr = 32'h82744E9C;
    logic [8:0]  st[4] = '{default: '0};
    logic [7:0]  hz[4] = '{default: '0}, lz[4] = '{default: '0};
    logic [7:0]  gm[4] = '{default: '0};
    logic [3:0]  fc[4] = '{4'h0, 4'h1, 4'h2, 4'hF};
    logic [7:0]  mem[4] = '{8'h01, 8'h03, 8'h00, 8'h80};
    logic [12:0] exp_q[$];
    logic [12:0] rd_val;
    event        rd_ev;
    int          errors = 0, n_checks = 0;

    always #50 serial_clock = ~serial_clock;

    pcsc_serial_config #(.PART_ID(PART_ID), .CAL_CODE(CAL_CODE)) u_dut (
        .serial_clock, .reset, .serial_data_in, .load_strobe,
        .serial_data_out, .comparator_a_state, .comparator_b_state,
        .external_level_select, .external_drive_enable, .lane_out,
        .continuity_test_circuit, .global_switch_control,
        .chipwide_cal_scale, .cal_busy, .cal_apply,
        .high_level_z_code, .low_level_z_code
    );
    pcsc_host_model u_host (
        .serial_clock, .serial_data_in, .load_strobe, .serial_data_out
    );

    // ========
    // Helpers
    function automatic logic [31:0] lfsr_step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_step
    function automatic logic [23:0] mk(input logic [12:0] d,
        input logic g, input logic [3:0] a, input logic c,
        input logic r, input logic [3:0] f);
        return {d, g, a, c, r, f};
    endfunction : mk
    task automatic chk(input string nm, input logic [12:0] s,
                       input logic [12:0] e);
        n_checks++;
        if (s !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic wr(input logic [23:0] w);
        logic [23:0] x;
        u_host.shift_word(w, x);
    endtask : wr
    // Readback leaves during the following idle word
    task automatic rd(input logic [23:0] w, input logic [12:0] e);
        logic [23:0] x;
        exp_q.push_back(e);
        u_host.shift_word(w, x);
        u_host.shift_word(24'h000000, x);
        rd_val = x[19:7];
        -> rd_ev;
    endtask : rd
    task automatic rd_lane(input int l, input logic [3:0] f);
        logic [12:0] e;
        case (f)
            4'h0: e = {2'b00, comparator_a_state[l],
                       comparator_b_state[l], st[l]};
            4'h1: e = {5'h00, hz[l]};
            4'h2: e = {5'h00, lz[l]};
            default: e = {5'h00, gm[l]};
        endcase
        rd(mk(13'h0000, 1'b0, 4'(l), 1'b1, 1'b1, f), e);
    endtask : rd_lane
    task automatic wr_lane(input int l, input logic [3:0] f,
                           input logic [12:0] d);
        case (f)
            4'h0: st[l] = d[8:0];
            4'h1: hz[l] = d[7:0];
            4'h2: lz[l] = d[7:0];
            default: gm[l] = d[7:0];
        endcase
        wr(mk(d, 1'b0, 4'(l), 1'b1, 1'b0, f));
    endtask : wr_lane
    task automatic drv_chk(input logic [1:0] e);
        u_host.idle(8);
        chk("drive", {11'h000, lane_out[1].drive_level,
            lane_out[1].drive_enable}, {11'h000, e});
    endtask : drv_chk
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done

    always @(rd_ev) chk("readback", rd_val, exp_q.pop_front());

    initial begin
        repeat (20000) @(posedge serial_clock);
        errors++;
        test_done();
    end

    // ========
    // Scenarios
    initial begin
        repeat (3) @(posedge serial_clock);
        reset                 <= 1'b0;
        comparator_a_state    <= lfsr[3:0];
        comparator_b_state    <= lfsr[7:4];
        external_level_select <= lfsr[11:8];
        external_drive_enable <= lfsr[15:12];
        u_host.idle(2);
        rd(mk(13'h0000, 1'b0, 4'h0, 1'b0, 1'b1, 4'h1), PART_ID);
        rd(mk(13'h0000, 1'b0, 4'h0, 1'b0, 1'b1, 4'h5), 13'h00FF);
        for (int i = 0; i < 4; i++) begin
            for (int l = 0; l < 4; l++) begin
                lfsr = lfsr_step(lfsr);
                rd_lane(l, fc[i]);
                wr_lane(l, fc[i], lfsr[12:0]);
                rd_lane(l, fc[i]);
            end
        end
        $display("test lane registers done");
        wr(mk(13'h1FFF, 1'b0, 4'h4, 1'b1, 1'b0, 4'h0));
        rd(mk(13'h0000, 1'b0, 4'h5, 1'b1, 1'b1, 4'h0), 13'h0000);
        rd_lane(3, 4'h0);
        wr_lane(1, 4'h0, 13'h0180);
        drv_chk(2'b01);
        wr_lane(1, 4'h0, 13'h0080);
        drv_chk({external_level_select[1], external_drive_enable[1]});
        $display("test address and override done");
        for (int l = 0; l < 4; l++)
            wr_lane(l, 4'hF, {5'h00, mem[l]});
        for (int g = 0; g < 8; g++) begin
            lfsr = lfsr_step(lfsr);
            wr(mk(lfsr[12:0], 1'b1, 4'(g), 1'b1, 1'b0, 4'h0));
            for (int l = 0; l < 4; l++)
                if (gm[l][g]) st[l] = lfsr[8:0];
            for (int l = 0; l < 4; l++)
                rd_lane(l, 4'h0);
        end
        wr(mk(13'h1FFF, 1'b1, 4'h0, 1'b1, 1'b1, 4'h0));
        rd_lane(0, 4'h0);
        $display("test group writes done");
        for (int l = 0; l < 4; l++)
            wr_lane(l, 4'h0, 13'h0000);
        wr(mk(13'h0001, 1'b0, 4'h0, 1'b0, 1'b0, 4'h3));
        rd(mk(13'h0000, 1'b0, 4'h0, 1'b0, 1'b1, 4'h3), 13'h0001);
        u_host.idle(600);
        for (int l = 0; l < 4; l++) begin
            hz[l] = CAL_CODE;
            lz[l] = CAL_CODE;
            rd_lane(l, 4'h1);
            rd_lane(l, 4'h2);
        end
        rd(mk(13'h0000, 1'b0, 4'h0, 1'b0, 1'b1, 4'h3), 13'h0000);
        $display("test calibration done");
        wr(mk(13'h0001, 1'b0, 4'h0, 1'b0, 1'b0, 4'h4));
        wr(mk({5'h00, lfsr[7:0]}, 1'b0, 4'h0, 1'b0, 1'b0, 4'h5));
        u_host.idle(3);
        chk("gsw", {12'h000, global_switch_control}, 13'h0001);
        chk("scale", {5'h00, chipwide_cal_scale}, {5'h00, lfsr[7:0]});
        wr(mk(13'h0001, 1'b0, 4'h0, 1'b0, 1'b0, 4'hF));
        gm = '{default: '0};
        rd_lane(1, 4'hF);
        rd(mk(13'h0000, 1'b0, 4'h0, 1'b0, 1'b1, 4'h5), 13'h00FF);
        $display("test chip registers done");
        test_done();
    end
endmodule : tb_pin_channel_serial_config
